// file: common/bus_size_pkg.sv
// Constants and types shared by the narrow-bus cycle sequencer and its lane stepper
package bus_size_pkg;
    localparam int           LANES           = 4;
    localparam int           MAX_FILL_CYCLES = 16;
    localparam logic [3:0]   ALL_LANES       = 4'hf;
    localparam logic [3:0]   NO_LANES        = 4'h0;
    localparam logic [3:0]   LOW_HALF        = 4'h3;
    localparam logic [3:0]   HIGH_HALF       = 4'hc;
    localparam logic [1:0]   FILL_WORDS_LEFT = 2'h3;
    localparam logic [1:0]   LEN_BYTE        = 2'h0;
    localparam logic [1:0]   LEN_WORD        = 2'h1;
    localparam logic [1:0]   LEN_DWORD       = 2'h2;

    typedef enum logic [2:0] {
        W32 = 3'h1,
        W16 = 3'h2,
        W8  = 3'h4
    } bus_width_t;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'h1,
        ST_ISSUE = 3'h2,
        ST_WAIT  = 3'h4
    } seq_state_t;
endpackage : bus_size_pkg

// file: src/lane_step.sv
// Remaining byte lanes after one bus cycle of the given width
`timescale 1ns/1ps
module lane_step
    import bus_size_pkg::*;
(
    input  wire logic [3:0]             mask,      // Lanes active in this cycle
    input  wire bus_size_pkg::bus_width_t width,   // Width the system answered with
    output logic      [3:0]             next_mask, // Lanes still to move
    output logic                        last       // Piece complete
);
    import bus_size_pkg::*;

    logic [3:0] lowest;
    logic [3:0] half;

    always_comb begin
        lowest = mask & (4'h0 - mask);
        half   = ((mask & LOW_HALF) != NO_LANES) ? LOW_HALF : HIGH_HALF;
        case (width)
            W8:      next_mask = mask & ~lowest;     // Lowest byte goes first
            W16:     next_mask = mask & ~half;       // Lower 2-byte word first
            default: next_mask = NO_LANES;
        endcase
        last = (next_mask == NO_LANES);
    end
endmodule : lane_step

// file: src/narrow_bus_byte_select.sv
// Processor-side bus cycle sequencer for 32-, 16- and 8-bit wide devices
//
// Contract
// - Issued lane patterns are contiguous and never empty; others are don't-care.
// - A narrow line fill issues as many cycles as needed, at most sixteen.
// - Later narrow fill cycles name exactly the bytes of the current word still to fetch.
// - An operand crossing a 4-byte word is split, one piece per word.
// - Split operands move the highest-order piece first.
// - Extra cycles forced by a width request move low-order bytes first.
// - Aligned dword under the 16-bit request: low two bytes, then high two.
// - A 3-byte piece under 16-bit: two cycles, lower-word bytes first, then upper-word bytes.
// - Byte-wide bus moves one byte per cycle, ascending within a piece.
// - The byte-wide request, alone or with the 16-bit one, selects 8 bits.
// - 16-bit request gives two or three cycles per dword; 8-bit gives four.
`timescale 1ns/1ps
module narrow_bus_byte_select
    import bus_size_pkg::*;
(
    input  wire logic        core_clk,           // 125 MHz clock
    input  wire logic        rstn,               // Async reset, active low
    input  wire logic        req_valid,          // Operand or line fill request
    output logic             req_ready,          // Sequencer idle
    input  wire logic [31:0] req_addr,           // Operand byte address
    input  wire logic [1:0]  req_len,            // Operand length code
    input  wire logic        req_fill,           // Cache line fill
    output logic             req_done,           // Request finished, one cycle
    output logic             cyc_start,          // Bus cycle begins, one cycle
    output logic             cyc_active,         // Bus cycle outstanding
    output logic [29:0]      cyc_addr,           // 4-byte word address
    output logic [3:0]       byte_lane_select_n, // Byte lanes, active low
    input  wire logic        cyc_done,           // Cycle ended by the system, pin
    input  wire logic        width8_request_n,   // Byte-wide request, pin
    input  wire logic        width16_request_n   // 16-bit request, pin
);
    import bus_size_pkg::*;

    typedef struct packed {
        seq_state_t  st;
        logic [3:0]  mask;
        logic [29:0] word;
        logic        pend_valid;
        logic [3:0]  pend_mask;
        logic [29:0] pend_word;
        logic [1:0]  fill_left;
        logic        is_fill;
        logic [4:0]  fill_cnt;
        logic        done;
        logic        d_s1;
        logic        d_s2;
        logic        w8_s1;
        logic        w8_s2;
        logic        w16_s1;
        logic        w16_s2;
    } seq_t;

    seq_t       r_r;
    seq_t       r_nxt;
    bus_width_t width;
    logic [3:0] step_next;
    logic       step_last;
    logic [2:0] nbytes;
    logic [7:0] span;
    logic       crosses;
    logic       accept;
    logic       answered;

    ////////////////////////////////////////////////////////////////////////////////
    // Request decode

    assign req_ready = (r_r.st == ST_IDLE);
    assign accept    = req_valid && req_ready;
    assign answered  = (r_r.st == ST_WAIT) && r_r.d_s2;

    always_comb begin
        case (req_len)
            LEN_BYTE: nbytes = 3'h1;
            LEN_WORD: nbytes = 3'h2;
            default:  nbytes = 3'h4;
        endcase
        // Byte span over two adjacent words; bits above 3 fall in the next word
        span    = ((8'h01 << nbytes) - 8'h01) << req_addr[1:0];
        crosses = (span[7:4] != NO_LANES);
    end

    // Byte-wide wins when both requests are seen
    always_comb begin
        if (!r_r.w8_s2) begin
            width = W8;
        end else if (!r_r.w16_s2) begin
            width = W16;
        end else begin
            width = W32;
        end
    end

    lane_step u_step (
        .mask      (r_r.mask),
        .width     (width),
        .next_mask (step_next),
        .last      (step_last)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Sequencer

    always_comb begin
        r_nxt        = r_r;
        r_nxt.done   = 1'b0;
        // Pins pass two flops; the width requests ride alongside the end of cycle
        r_nxt.d_s1   = cyc_done;
        r_nxt.d_s2   = r_r.d_s1;
        r_nxt.w8_s1  = width8_request_n;
        r_nxt.w8_s2  = r_r.w8_s1;
        r_nxt.w16_s1 = width16_request_n;
        r_nxt.w16_s2 = r_r.w16_s1;
        case (r_r.st)
            ST_IDLE: begin
                if (accept) begin
                    r_nxt.st       = ST_ISSUE;
                    r_nxt.is_fill  = req_fill;
                    r_nxt.fill_cnt = 5'h00;
                    if (req_fill) begin
                        r_nxt.mask       = ALL_LANES;
                        r_nxt.word       = req_addr[31:2];
                        r_nxt.fill_left  = FILL_WORDS_LEFT;
                        r_nxt.pend_valid = 1'b0;
                    end else if (crosses) begin
                        r_nxt.mask       = span[7:4];
                        r_nxt.word       = req_addr[31:2] + 30'h1;
                        r_nxt.pend_valid = 1'b1;
                        r_nxt.pend_mask  = span[3:0];
                        r_nxt.pend_word  = req_addr[31:2];
                        r_nxt.fill_left  = 2'h0;
                    end else begin
                        r_nxt.mask       = span[3:0];
                        r_nxt.word       = req_addr[31:2];
                        r_nxt.pend_valid = 1'b0;
                        r_nxt.fill_left  = 2'h0;
                    end
                end
            end
            ST_ISSUE: begin
                r_nxt.st = ST_WAIT;
                if (r_r.is_fill) begin
                    r_nxt.fill_cnt = r_r.fill_cnt + 5'h01;
                end
            end
            ST_WAIT: begin
                if (r_r.d_s2) begin
                    if (!step_last) begin
                        r_nxt.mask = step_next;
                        r_nxt.st   = ST_ISSUE;
                    end else if (r_r.pend_valid) begin
                        r_nxt.mask       = r_r.pend_mask;
                        r_nxt.word       = r_r.pend_word;
                        r_nxt.pend_valid = 1'b0;
                        r_nxt.st         = ST_ISSUE;
                    end else if (r_r.fill_left != 2'h0) begin
                        // Next word of the line, wrapping inside the 16-byte area
                        r_nxt.word      = {r_r.word[29:2], r_r.word[1:0] + 2'h1};
                        r_nxt.mask      = ALL_LANES;
                        r_nxt.fill_left = r_r.fill_left - 2'h1;
                        r_nxt.st        = ST_ISSUE;
                    end else begin
                        r_nxt.mask = NO_LANES;
                        r_nxt.done = 1'b1;
                        r_nxt.st   = ST_IDLE;
                    end
                end
            end
            default: begin
                r_nxt.st = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            r_r <= '{st: ST_IDLE, mask: 4'h0, word: 30'h0, pend_valid: 1'b0,
                     pend_mask: 4'h0, pend_word: 30'h0, fill_left: 2'h0,
                     is_fill: 1'b0, fill_cnt: 5'h00, done: 1'b0, d_s1: 1'b0,
                     d_s2: 1'b0, w8_s1: 1'b1, w8_s2: 1'b1, w16_s1: 1'b1, w16_s2: 1'b1};
        end else begin
            r_r <= r_nxt;
        end
    end

    assign cyc_start          = (r_r.st == ST_ISSUE);
    assign cyc_active         = (r_r.st == ST_WAIT);
    assign cyc_addr           = r_r.word;
    assign byte_lane_select_n = ~r_r.mask;                  // Idle shows all lanes negated
    assign req_done           = r_r.done;

    ////////////////////////////////////////////////////////////////////////////////
    // Checks

    lanes_contig_a: assert property (@(posedge core_clk) disable iff (!rstn)
        cyc_start |-> (r_r.mask inside {4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'h6, 4'hc,
                                        4'h7, 4'he, 4'hf}))
        else $error("non-contiguous or empty lane pattern issued");

    fill_count_a: assert property (@(posedge core_clk) disable iff (!rstn)
        (r_r.fill_cnt <= 5'(MAX_FILL_CYCLES)))
        else $error("line fill used more than sixteen cycles");

    fill_remaining_a: assert property (@(posedge core_clk) disable iff (!rstn)
        (answered && r_r.is_fill && !step_last) |=> (cyc_start && r_r.mask == $past(step_next)))
        else $error("fill cycle lanes do not match remaining bytes");

    unaligned_split_a: assert property (@(posedge core_clk) disable iff (!rstn)
        (accept && !req_fill && crosses) |=> (r_r.pend_valid &&
                                              r_r.pend_word == $past(req_addr[31:2])))
        else $error("word-crossing operand not split");

    high_first_a: assert property (@(posedge core_clk) disable iff (!rstn)
        (accept && !req_fill && crosses) |=> (cyc_start &&
                                              r_r.word == $past(req_addr[31:2]) + 30'h1))
        else $error("split operand did not start with the high word");

    low_half_first_a: assert property (@(posedge core_clk) disable iff (!rstn)
        (answered && width == W16 && (r_r.mask & LOW_HALF) != NO_LANES &&
         (r_r.mask & HIGH_HALF) != NO_LANES) |=> (r_r.mask == ($past(r_r.mask) & HIGH_HALF)))
        else $error("16-bit split did not take the low half first");

    byte_width_a: assert property (@(posedge core_clk) disable iff (!rstn)
        (answered && !r_r.w8_s2 && $countones(r_r.mask) > 1) |=>
            ($countones(r_r.mask) == $countones($past(r_r.mask)) - 1))
        else $error("byte-wide answer did not advance by one byte");

    done_after_last_a: assert property (@(posedge core_clk) disable iff (!rstn)
        req_done |-> $past(answered && step_last && !r_r.pend_valid && r_r.fill_left == 2'h0))
        else $error("request finished with bytes still pending");

    dword_16_a: assert property (@(posedge core_clk) disable iff (!rstn)
        (answered && width != W32 && !step_last) |=> ((r_r.mask & ($past(r_r.mask) &
                                                       (4'h0 - $past(r_r.mask)))) == NO_LANES))
        else $error("narrow answer did not drop the lowest byte");
endmodule : narrow_bus_byte_select

// file: bench/narrow_mem_model.sv
// Behavioural memory system of mixed widths answering the sequencer's bus cycles
`timescale 1ns/1ps
module narrow_mem_model (
    input  wire logic       core_clk,            // Bus clock
    input  wire logic       cyc_start,           // New bus cycle
    input  wire logic [3:0] byte_lane_select_n,  // Byte lanes, active low
    input  wire logic [1:0] width_mode,          // 0: 32, 1: 16, 2: 8, 3: both requests
    input  wire logic [3:0] answer_lat,          // Cycles from start to end, at least 1
    input  wire logic       fill_first,          // First cycle of a line fill
    output logic            cyc_done,            // Ends the cycle, one cycle
    output logic            width8_request_n,    // Byte-wide request
    output logic            width16_request_n,   // 16-bit request
    output logic            addr_bit1,           // Decoded address bit 1
    output logic            upper_lane_select_n, // Decoded high byte lane
    output logic            lower_lane_select_n, // Decoded low byte lane, also address bit 0
    output logic [1:0]      swap_lane            // Processor lane routed to narrow byte 0
);
    logic a1_raw;
    logic bhe_raw;
    logic ble_raw;

    ////////////////////////////////////////////////////////////////////////////////
    // Lane decoder, kept combinational so it follows the lanes in the same clock
    // Gapped or empty lane patterns never occur, so they decode to anything
    assign a1_raw              = byte_lane_select_n[0] & byte_lane_select_n[1];
    assign bhe_raw             = byte_lane_select_n[1] & byte_lane_select_n[3];
    assign ble_raw             = byte_lane_select_n[0]
                               & (byte_lane_select_n[2] | ~byte_lane_select_n[1]);
    // First line fill cycle decodes as if every lane were active
    assign addr_bit1           = a1_raw & ~fill_first;
    assign upper_lane_select_n = bhe_raw & ~fill_first;
    assign lower_lane_select_n = ble_raw & ~fill_first;
    // Byte swapper select: 16-bit keeps A0 at zero, 8-bit uses both address bits
    assign swap_lane = (width_mode == 2'h0) ? 2'h0 :
                       (width_mode == 2'h1) ? {addr_bit1, 1'b0} :
                                              {addr_bit1, lower_lane_select_n};

    ////////////////////////////////////////////////////////////////////////////////
    // Width pins are valid only in the ending cycle; pull-ups hold them negated otherwise
    initial begin
        cyc_done          = 1'b0;
        width8_request_n  = 1'b1;
        width16_request_n = 1'b1;
        forever begin
            @(posedge core_clk);
            #1;
            if (cyc_start === 1'b1) begin
                repeat (answer_lat) @(posedge core_clk);
                #1;
                cyc_done          = 1'b1;
                width16_request_n = ~width_mode[0];
                width8_request_n  = ~width_mode[1];
                @(posedge core_clk);
                #1;
                cyc_done          = 1'b0;
                width8_request_n  = 1'b1;
                width16_request_n = 1'b1;
            end
        end
    end
endmodule : narrow_mem_model

// file: bench/narrow_bus_byte_select_tb_top.sv
// Self-checking testbench for the narrow-bus cycle sequencer
`timescale 1ns/1ps
module narrow_bus_byte_select_tb_top;
    import bus_size_pkg::*;
    logic        core_clk, rstn, req_valid, req_ready, req_fill, req_done;
    logic        cyc_start, cyc_active, cyc_done, w8_n, w16_n;
    logic [31:0] req_addr;
    logic [1:0]  req_len, width_mode;
    logic [3:0]  answer_lat, lanes_n;
    logic [29:0] cyc_addr;
    logic        fill_first, dec_a1, dec_bhe_n, dec_ble_n;
    logic [1:0]  swap_lane;
    logic [4:0]  dec_got;
    int          fail_count = 0;
    int          checked = 0;

    narrow_bus_byte_select u_dut (.core_clk(core_clk), .rstn(rstn), .req_valid(req_valid),
        .req_ready(req_ready), .req_addr(req_addr), .req_len(req_len), .req_fill(req_fill),
        .req_done(req_done), .cyc_start(cyc_start), .cyc_active(cyc_active),
        .cyc_addr(cyc_addr), .byte_lane_select_n(lanes_n), .cyc_done(cyc_done),
        .width8_request_n(w8_n), .width16_request_n(w16_n));

    narrow_mem_model u_mem (.core_clk(core_clk), .cyc_start(cyc_start),
        .byte_lane_select_n(lanes_n), .width_mode(width_mode), .answer_lat(answer_lat),
        .fill_first(fill_first),
        .cyc_done(cyc_done), .width8_request_n(w8_n), .width16_request_n(w16_n),
        .addr_bit1(dec_a1), .upper_lane_select_n(dec_bhe_n), .lower_lane_select_n(dec_ble_n),
        .swap_lane(swap_lane));

    assign dec_got = {dec_a1, dec_bhe_n, dec_ble_n, swap_lane};

    always #4 core_clk = ~core_clk;

    ////////////////////////////////////////////////////////////////////////////////
    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : print_verdict

    task automatic check_val(input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask : check_val

    task automatic check_reset_out();
        check_val(32'hf, {28'h0, lanes_n});
        check_val(32'h1, {31'h0, req_ready});
        check_val(32'h0, {29'h0, req_done, cyc_start, cyc_active});
        check_val(32'h0, {2'h0, cyc_addr});
    endtask : check_reset_out

    // Expected {A1, upper, lower, swap lane} for the lanes a narrow system sees
    function automatic logic [4:0] exp_decode(input logic [3:0] ln, input logic first,
                                              input logic [1:0] mode);
        logic [2:0] d;
        case (ln)
            4'he:             d = 3'h2;
            4'hd, 4'h9, 4'h1: d = 3'h1;
            4'hb:             d = 3'h6;
            4'h7:             d = 3'h5;
            4'h3:             d = 3'h4;
            default:          d = 3'h0;
        endcase
        if (first)
            d = 3'h0;
        if (mode == 2'h0)
            return {d, 2'h0};
        else if (mode == 2'h1)
            return {d, d[2], 1'b0};
        else
            return {d, d[2], d[0]};
    endfunction : exp_decode

    // Waits for a flag in the current or a later cycle; a spent bound ends the run
    task automatic wait_flag(input bit for_done);
        int i;
        for (i = 0; i < 60; i++) begin
            if ((for_done ? req_done : cyc_start) === 1'b1)
                return;
            if (for_done)
                check_val(32'h0, {31'h0, cyc_start});
            @(posedge core_clk);
            #1;
        end
        fail_count++;
        print_verdict();
    endtask : wait_flag

    // Lanes hold one nibble per cycle, word offsets in the line two bits per cycle
    task automatic run_req(input logic [31:0] addr, input logic [1:0] len, input logic fill,
                           input logic [1:0] mode, input logic [3:0] lat, input int n,
                           input logic [63:0] lanes, input logic [31:0] woffs);
        int i;
        int k;
        logic [4:0] dexp;
        width_mode = mode;
        fill_first = fill;
        answer_lat = lat;
        req_addr   = addr;
        req_len    = len;
        req_fill   = fill;
        req_valid  = 1'b1;
        for (i = 0; i < 60 && req_ready !== 1'b1; i++) begin
            @(posedge core_clk);
            #1;
        end
        if (req_ready !== 1'b1) begin
            fail_count++;
            print_verdict();
        end
        @(posedge core_clk);
        #1;
        req_valid = 1'b0;
        for (k = 0; k < n; k++) begin
            wait_flag(1'b0);
            check_val({28'h0, lanes[k*4+:4]}, {28'h0, lanes_n});
            check_val({2'h0, addr[31:4], woffs[k*2+:2]}, {2'h0, cyc_addr});
            check_val(32'h0, {31'h0, cyc_active});
            dexp = exp_decode(lanes[k*4+:4], fill && (k == 0), mode);
            check_val({27'h0, dexp}, {27'h0, dec_got});
            @(posedge core_clk);
            #1;
            fill_first = 1'b0;
            check_val(32'h1, {31'h0, cyc_active});
        end
        wait_flag(1'b1);
        check_val(32'h1, {31'h0, req_ready});
    endtask : run_req

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_dword32();
        run_req(32'h0000_1000, LEN_DWORD, 1'b0, 2'h0, 4'h1, 1, 64'h0, 32'h0);
    endtask : t_dword32
    // Reset in the middle of a bus cycle; the late answer must be ignored
    task automatic t_reset_mid();
        width_mode = 2'h1;
        answer_lat = 4'h8;
        req_addr   = 32'h0000_2000;
        req_len    = LEN_DWORD;
        req_fill   = 1'b0;
        fill_first = 1'b0;
        req_valid  = 1'b1;
        @(posedge core_clk);
        #1;
        req_valid = 1'b0;
        @(posedge core_clk);
        #1;
        check_val(32'h1, {31'h0, cyc_active});
        rstn = 1'b0;
        #1;
        check_reset_out();
        repeat (2) @(posedge core_clk);
        #1;
        rstn = 1'b1;
        check_reset_out();
        repeat (12) @(posedge core_clk);
        #1;
        check_reset_out();
    endtask : t_reset_mid
    task automatic t_byte16();
        run_req(32'h0000_1002, LEN_BYTE, 1'b0, 2'h1, 4'h2, 1, 64'hb, 32'h0);
    endtask : t_byte16
    task automatic t_dword16();
        run_req(32'h0000_1000, LEN_DWORD, 1'b0, 2'h1, 4'h3, 2, 64'h30, 32'h0);
    endtask : t_dword16
    task automatic t_dword8_both();
        run_req(32'h0000_1000, LEN_DWORD, 1'b0, 2'h3, 4'h1, 4, 64'h7310, 32'h0);
    endtask : t_dword8_both
    task automatic t_unaligned32();
        run_req(32'h0000_1003, LEN_DWORD, 1'b0, 2'h0, 4'h2, 2, 64'h78, 32'h1);
    endtask : t_unaligned32
    task automatic t_unaligned16();
        run_req(32'h0000_1003, LEN_DWORD, 1'b0, 2'h1, 4'h1, 3, 64'h7b8, 32'h5);
    endtask : t_unaligned16
    task automatic t_word16_split();
        run_req(32'h0000_1001, LEN_WORD, 1'b0, 2'h1, 4'h1, 2, 64'hb9, 32'h0);
    endtask : t_word16_split
    task automatic t_word8_cross();
        run_req(32'h0000_1003, LEN_WORD, 1'b0, 2'h2, 4'h4, 2, 64'h7e, 32'h1);
    endtask : t_word8_cross
    task automatic t_fill8();
        run_req(32'h0000_1008, LEN_BYTE, 1'b1, 2'h2, 4'h1, 16, 64'h7310_7310_7310_7310,
                32'h5500_ffaa);
    endtask : t_fill8

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        core_clk   = 1'b0;
        rstn       = 1'b0;
        req_valid  = 1'b0;
        req_addr   = 32'h0;
        req_len    = 2'h0;
        req_fill   = 1'b0;
        width_mode = 2'h0;
        answer_lat = 4'h1;
        fill_first = 1'b0;
        repeat (20) @(posedge core_clk);
        #1;
        check_reset_out();
        rstn = 1'b1;
        t_dword32();
        t_reset_mid();
        t_byte16();
        t_dword16();
        t_dword8_both();
        t_unaligned32();
        t_unaligned16();
        t_word16_split();
        t_word8_cross();
        t_fill8();
        print_verdict();
    end
endmodule : narrow_bus_byte_select_tb_top
